// *** logic/dtr_pll_defines.vh ***
// Constants for the timing PLL control block: register map, fields, resets, timing.
// Assumes inclusion by the design file only; holds definitions and nothing else.
`ifndef DTR_PLL_DEFINES_VH
`define DTR_PLL_DEFINES_VH

// ==========================================================
// Register byte offsets on the AXI4-Lite slave
`define DTR_ADDR_W 8
`define DTR_OFS_REF_CHANGE 8'h00
`define DTR_OFS_PLL_CTRL 8'h04
`define DTR_OFS_SW_DELTA 8'h08
`define DTR_OFS_CENTRE 8'h0c
`define DTR_OFS_BANDWIDTH 8'h10
`define DTR_OFS_LOCK_RANGE 8'h14
`define DTR_OFS_LOCK_THRESH 8'h18
`define DTR_OFS_LOCK_INTV 8'h1c
`define DTR_OFS_REF_PERIOD 8'h20
`define DTR_OFS_STATUS 8'h24
`define DTR_OFS_OFFSET_NOW 8'h28

// ==========================================================
// Field positions
`define DTR_MODE_LO 0
`define DTR_REFSEL_LO 2
`define DTR_PMS_LO 4
`define DTR_CTL_IRM 0
`define DTR_CTL_SWE 3
`define DTR_CTL_SWF 4
`define DTR_BW_LPF_LO 0
`define DTR_BW_SLOPE_LO 4
`define DTR_BW_BYPASS 13
`define DTR_ST_FAIL_LO 0
`define DTR_ST_MCHG 4
`define DTR_ST_LOCK 5
`define DTR_ST_HOLD 6
`define DTR_ST_ACT_LO 8

// ==========================================================
// Mode and preference encodings
`define DTR_MODE_NORMAL 2'h0
`define DTR_MODE_HOLD 2'h1
`define DTR_MODE_AUTO 2'h2
`define DTR_MODE_FREE 2'h3
`define DTR_PMS_ROUND 3'h0
`define DTR_PMS_PREF 3'h1

// ==========================================================
// Reset values
`define DTR_RST_REF_CHANGE 7'h00
`define DTR_RST_CENTRE 32'h0a7c5ac4
`define DTR_RST_BANDWIDTH 14'h0384
`define DTR_RST_LOCK_RANGE 14'h0371
`define DTR_RST_LOCK_THRESH 16'h0040
`define DTR_RST_LOCK_INTV 8'h04
`define DTR_RST_REF_PERIOD 24'h000c35

// ==========================================================
// Timing: lock detector step, holdover history and frame length
`define DTR_CLK_KHZ 25000
`define DTR_STEP_MS 4
`define DTR_HIST_DEPTH 4
`define DTR_FRAME_LEN 16'h0040

`endif

// *** logic/dtr_pll_ctrl.v ***
// Control logic of the timing PLL: modes, reference choice, NCO and holdover.
// Assumes a 25 MHz aclk, synchronous inputs, and an AXI4-Lite master for access.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "dtr_pll_defines.vh"

module dtr_pll_ctrl #(
	parameter STEP_CYCLES = `DTR_STEP_MS * `DTR_CLK_KHZ
) (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [3:0] timing_reference_inputs,
	input wire [3:0] ref_ok,
	output reg [5:0] pll_clk_out,
	output reg [4:0] pll_frame_out,
	output reg pll_locked,
	output reg holdover_active,
	output reg [1:0] active_ref
);

	localparam ST_NORM = 1'b0;
	localparam ST_HOLD = 1'b1;

	// ==========================================================
	// Registers
	reg [6:0] reference_change_control_reg;
	reg [4:0] pll_control_reg;
	reg [15:0] software_delta_frequency_reg;
	reg [31:0] centre_freq_reg;
	reg [13:0] bandwidth_control_reg;
	reg [13:0] locking_range_reg;
	reg [15:0] lock_threshold_reg;
	reg [7:0] lock_interval_reg;
	reg [23:0] ref_period_reg;
	reg [3:0] ref_fail_flag;
	reg mode_change_flag;

	wire [1:0] mode = reference_change_control_reg[`DTR_MODE_LO+1:`DTR_MODE_LO];
	wire [1:0] ref_sel = reference_change_control_reg[`DTR_REFSEL_LO+1:`DTR_REFSEL_LO];
	wire [2:0] pms = reference_change_control_reg[`DTR_PMS_LO+2:`DTR_PMS_LO];
	wire irm = pll_control_reg[`DTR_CTL_IRM];
	wire software_mode_enable = pll_control_reg[`DTR_CTL_SWE];
	wire software_offset_immediate = pll_control_reg[`DTR_CTL_SWF];
	wire [3:0] lpf = bandwidth_control_reg[`DTR_BW_LPF_LO+3:`DTR_BW_LPF_LO];
	wire [7:0] slope = bandwidth_control_reg[`DTR_BW_SLOPE_LO+7:`DTR_BW_SLOPE_LO];
	wire bypass = bandwidth_control_reg[`DTR_BW_BYPASS];

	// ==========================================================
	// AXI4-Lite slave
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	assign s_axi_awready = clk_en & ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = clk_en & ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = clk_en & ~s_axi_rvalid;

	wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wd = w_held ? w_data : s_axi_wdata;
	wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
	wire aw_ok = aw_held | (s_axi_awvalid & s_axi_awready);
	wire w_ok = w_held | (s_axi_wvalid & s_axi_wready);
	wire do_wr = clk_en & aw_ok & w_ok & ~s_axi_bvalid;
	wire wr_map = (wa <= `DTR_OFS_REF_PERIOD) && (wa[1:0] == 2'h0);

	// Byte-lane merge of a write into the previous word.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (strb[b])
					merge[8*b+:8] = nw[8*b+:8];
		end
	endfunction

	// Address and data are caught separately, in either order.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else if (clk_en)
		begin
			if (s_axi_awvalid && s_axi_awready && !do_wr)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready && !do_wr)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_map || wa == `DTR_OFS_STATUS) ? 2'h0 : 2'h2;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Core state declarations
	reg [31:0] nco_acc;
	reg signed [15:0] offset;
	reg signed [15:0] goal;
	reg auto_st;
	reg [1:0] cur_ref;
	reg [3:0] ref_prev;
	reg [3:0] ok_prev;
	reg [1:0] eff_prev;
	reg [23:0] per_cnt;
	reg edge_seen;
	reg [31:0] step_cnt;
	reg [7:0] good_steps;
	reg err_big;
	reg [15:0] frame_cnt;
	reg msb_prev;
	reg signed [15:0] hist [0:`DTR_HIST_DEPTH-1];

	// Effective mode: automatic resolves to tracking or holding.
	wire in_free = (mode == `DTR_MODE_FREE);
	wire tracking = (mode == `DTR_MODE_NORMAL) || (mode == `DTR_MODE_AUTO && auto_st == ST_NORM);
	wire holding = (mode == `DTR_MODE_HOLD) || (mode == `DTR_MODE_AUTO && auto_st == ST_HOLD);
	wire [1:0] eff = in_free ? 2'h3 : (holding ? 2'h1 : 2'h0);
	wire sw_on = in_free & software_mode_enable;
	wire step_tick = (step_cnt == STEP_CYCLES - 1);

	// Read mux; unmapped addresses return zero with a slave error.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else if (clk_en)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				if (s_axi_araddr == `DTR_OFS_REF_CHANGE)
					s_axi_rdata <= {25'h0, reference_change_control_reg};
				else if (s_axi_araddr == `DTR_OFS_PLL_CTRL)
					s_axi_rdata <= {27'h0, pll_control_reg};
				else if (s_axi_araddr == `DTR_OFS_SW_DELTA)
					s_axi_rdata <= {16'h0, software_delta_frequency_reg};
				else if (s_axi_araddr == `DTR_OFS_CENTRE)
					s_axi_rdata <= centre_freq_reg;
				else if (s_axi_araddr == `DTR_OFS_BANDWIDTH)
					s_axi_rdata <= {18'h0, bandwidth_control_reg};
				else if (s_axi_araddr == `DTR_OFS_LOCK_RANGE)
					s_axi_rdata <= {18'h0, locking_range_reg};
				else if (s_axi_araddr == `DTR_OFS_LOCK_THRESH)
					s_axi_rdata <= {16'h0, lock_threshold_reg};
				else if (s_axi_araddr == `DTR_OFS_LOCK_INTV)
					s_axi_rdata <= {24'h0, lock_interval_reg};
				else if (s_axi_araddr == `DTR_OFS_REF_PERIOD)
					s_axi_rdata <= {8'h0, ref_period_reg};
				else if (s_axi_araddr == `DTR_OFS_STATUS)
					s_axi_rdata <= {22'h0, active_ref, 1'b0, holdover_active, pll_locked,
						mode_change_flag, ref_fail_flag};
				else if (s_axi_araddr == `DTR_OFS_OFFSET_NOW)
					s_axi_rdata <= {16'h0, offset};
				else
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Previous contents of the addressed register, widened to a bus word for the lane merge.
	reg [31:0] old_word;
	always @*
	begin
		old_word = 32'h00000000;
		if (wa == `DTR_OFS_REF_CHANGE)
			old_word = {25'h0, reference_change_control_reg};
		else if (wa == `DTR_OFS_PLL_CTRL)
			old_word = {27'h0, pll_control_reg};
		else if (wa == `DTR_OFS_SW_DELTA)
			old_word = {16'h0, software_delta_frequency_reg};
		else if (wa == `DTR_OFS_CENTRE)
			old_word = centre_freq_reg;
		else if (wa == `DTR_OFS_BANDWIDTH)
			old_word = {18'h0, bandwidth_control_reg};
		else if (wa == `DTR_OFS_LOCK_RANGE)
			old_word = {18'h0, locking_range_reg};
		else if (wa == `DTR_OFS_LOCK_THRESH)
			old_word = {16'h0, lock_threshold_reg};
		else if (wa == `DTR_OFS_LOCK_INTV)
			old_word = {24'h0, lock_interval_reg};
		else if (wa == `DTR_OFS_REF_PERIOD)
			old_word = {8'h0, ref_period_reg};
	end
	wire [31:0] new_word = merge(old_word, wd, ws);

	// Register writes; internal reset mode never touches these.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			reference_change_control_reg <= `DTR_RST_REF_CHANGE;
			pll_control_reg <= 5'h00;
			software_delta_frequency_reg <= 16'h0000;
			centre_freq_reg <= `DTR_RST_CENTRE;
			bandwidth_control_reg <= `DTR_RST_BANDWIDTH;
			locking_range_reg <= `DTR_RST_LOCK_RANGE;
			lock_threshold_reg <= `DTR_RST_LOCK_THRESH;
			lock_interval_reg <= `DTR_RST_LOCK_INTV;
			ref_period_reg <= `DTR_RST_REF_PERIOD;
		end
		else if (do_wr)
		begin
			if (wa == `DTR_OFS_REF_CHANGE)
				reference_change_control_reg <= new_word[6:0];
			else if (wa == `DTR_OFS_PLL_CTRL)
				pll_control_reg <= new_word[4:0] & 5'h19;
			else if (wa == `DTR_OFS_SW_DELTA)
				software_delta_frequency_reg <= new_word[15:0];
			else if (wa == `DTR_OFS_CENTRE)
				centre_freq_reg <= new_word;
			else if (wa == `DTR_OFS_BANDWIDTH)
				bandwidth_control_reg <= new_word[13:0];
			else if (wa == `DTR_OFS_LOCK_RANGE)
				locking_range_reg <= new_word[13:0];
			else if (wa == `DTR_OFS_LOCK_THRESH)
				lock_threshold_reg <= new_word[15:0];
			else if (wa == `DTR_OFS_LOCK_INTV)
				lock_interval_reg <= new_word[7:0];
			else if (wa == `DTR_OFS_REF_PERIOD)
				ref_period_reg <= new_word[23:0];
		end
	end

	// ==========================================================
	// Reference choice for the automatic state machine
	reg [1:0] pick;
	reg pick_ok;
	reg [1:0] cand;
	integer k;
	always @*
	begin
		pick = cur_ref;
		pick_ok = 1'b0;
		cand = 2'h0;
		if (pms == `DTR_PMS_PREF)
		begin
			// Primary first, then its next neighbour, never a third.
			if (ref_ok[ref_sel])
			begin
				pick = ref_sel;
				pick_ok = 1'b1;
			end
			else if (ref_ok[ref_sel + 2'h1])
			begin
				pick = ref_sel + 2'h1;
				pick_ok = 1'b1;
			end
		end
		else if (ref_ok[cur_ref])
			pick_ok = 1'b1;
		else
		begin
			// Search onward in circular order from the current reference.
			for (k = 3; k >= 1; k = k - 1)
			begin
				cand = cur_ref + k[1:0];
				if (ref_ok[cand])
				begin
					pick = cand;
					pick_ok = 1'b1;
				end
			end
		end
	end

	// Automatic mode: tracking while a reference is eligible, else holding.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			auto_st <= ST_NORM;
			cur_ref <= 2'h0;
		end
		else if (clk_en)
		begin
			if (mode != `DTR_MODE_AUTO)
			begin
				auto_st <= ST_NORM;
				cur_ref <= ref_sel;
			end
			else
			begin
				case (auto_st)
					ST_NORM:
						if (pick_ok)
							cur_ref <= pick;
						else
							auto_st <= ST_HOLD;
					default:
						if (pick_ok)
						begin
							cur_ref <= pick;
							auto_st <= ST_NORM;
						end
				endcase
			end
		end
	end

	// ==========================================================
	// Reference period measurement, lock detector, offset steering
	wire ref_edge = timing_reference_inputs[cur_ref] & ~ref_prev[cur_ref];
	wire signed [24:0] err = $signed({1'b0, ref_period_reg}) - $signed({1'b0, per_cnt});
	wire [24:0] err_abs = err[24] ? 25'h0 - err : err;
	wire signed [24:0] trk_raw = $signed({{9{offset[15]}}, offset}) + (err >>> lpf);
	wire signed [24:0] lim = $signed({11'h0, locking_range_reg});
	wire signed [24:0] trk = (trk_raw > lim) ? lim : ((trk_raw < -lim) ? -lim : trk_raw);
	wire signed [16:0] diff = $signed({goal[15], goal}) - $signed({offset[15], offset});
	wire signed [16:0] sl = $signed({9'h0, slope});
	wire sw_write = do_wr && (wa == `DTR_OFS_SW_DELTA);
	wire [15:0] sw_new = new_word[15:0];

	// History of the tracked offset, shifted on each step while tracking.
	genvar g;
	generate
		for (g = 0; g < `DTR_HIST_DEPTH; g = g + 1)
		begin : g_hist
			always @(posedge aclk)
			begin
				if (!aresetn || irm)
					hist[g] <= 16'h0000;
				else if (clk_en && step_tick && tracking)
					hist[g] <= (g == 0) ? offset : hist[(g == 0) ? 0 : g - 1];
			end
		end
	endgenerate

	// Steering of the frequency offset; internal reset mode holds it cleared.
	always @(posedge aclk)
	begin
		if (!aresetn || irm)
		begin
			offset <= 16'h0000;
			goal <= 16'h0000;
			per_cnt <= 24'h000000;
			edge_seen <= 1'b0;
			step_cnt <= 32'h00000000;
			good_steps <= 8'h00;
			err_big <= 1'b0;
			pll_locked <= 1'b0;
			ref_prev <= 4'h0;
			eff_prev <= 2'h0;
		end
		else if (clk_en)
		begin
			ref_prev <= timing_reference_inputs;
			eff_prev <= eff;
			step_cnt <= step_tick ? 32'h00000000 : step_cnt + 32'h00000001;
			per_cnt <= ref_edge ? 24'h000001 : per_cnt + 24'h000001;
			if (in_free)
			begin
				// Centre frequency only, unless software steering is on.
				edge_seen <= 1'b0;
				pll_locked <= 1'b0;
				goal <= sw_on ? software_delta_frequency_reg : 16'h0000;
				if (sw_on && software_offset_immediate && sw_write)
				begin
					offset <= sw_new;
					goal <= sw_new;
				end
				else if (!sw_on || eff_prev != 2'h3)
					offset <= sw_on && software_offset_immediate ? software_delta_frequency_reg : 16'h0000;
				else if (step_tick)
				begin
					// Approach at the slope limit unless bypassed.
					if (bypass || (diff <= sl && diff >= -sl))
						offset <= goal;
					else
						offset <= offset + (diff[16] ? -sl[15:0] : sl[15:0]);
				end
			end
			else if (holding)
			begin
				// Restore the oldest saved value, not the latest.
				edge_seen <= 1'b0;
				pll_locked <= 1'b0;
				if (eff_prev != 2'h1)
					offset <= hist[`DTR_HIST_DEPTH-1];
			end
			else if (ref_edge)
			begin
				edge_seen <= 1'b1;
				if (edge_seen)
				begin
					// Filtered period error, clamped to the locking range.
					offset <= trk[15:0];
					if (err_abs > {9'h0, lock_threshold_reg})
						err_big <= 1'b1;
				end
			end
			// Lock needs the whole interval of clean 4 ms steps.
			if (tracking && step_tick)
			begin
				err_big <= 1'b0;
				if (err_big || !edge_seen)
				begin
					good_steps <= 8'h00;
					pll_locked <= 1'b0;
				end
				else if (good_steps >= lock_interval_reg)
					pll_locked <= 1'b1;
				else
					good_steps <= good_steps + 8'h01;
			end
		end
	end

	// ==========================================================
	// Sticky status: hardware set wins over software clear.
	wire st_clr = do_wr && (wa == `DTR_OFS_STATUS) && ws[0];
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_fail
			always @(posedge aclk)
			begin
				if (!aresetn)
					ref_fail_flag[g] <= 1'b0;
				else if (clk_en)
				begin
					if (ok_prev[g] && !ref_ok[g])
						ref_fail_flag[g] <= 1'b1;
					else if (st_clr && wd[`DTR_ST_FAIL_LO+g])
						ref_fail_flag[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Mode or active reference changes latch a flag; status outputs follow.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ok_prev <= 4'h0;
			mode_change_flag <= 1'b0;
			holdover_active <= 1'b0;
			active_ref <= 2'h0;
		end
		else if (clk_en)
		begin
			ok_prev <= ref_ok;
			holdover_active <= holding;
			active_ref <= cur_ref;
			if (eff != eff_prev || active_ref != cur_ref)
				mode_change_flag <= 1'b1;
			else if (st_clr && wd[`DTR_ST_MCHG])
				mode_change_flag <= 1'b0;
		end
	end

	// ==========================================================
	// NCO: centre word plus offset; taps give the clocks and frame pulses.
	wire [31:0] fword = centre_freq_reg + {{16{offset[15]}}, offset};
	always @(posedge aclk)
	begin
		if (!aresetn || irm)
		begin
			nco_acc <= 32'h00000000;
			msb_prev <= 1'b0;
			frame_cnt <= 16'h0000;
		end
		else if (clk_en)
		begin
			nco_acc <= nco_acc + fword;
			msb_prev <= nco_acc[31];
			if (nco_acc[31] && !msb_prev)
				frame_cnt <= (frame_cnt == `DTR_FRAME_LEN - 16'h0001) ? 16'h0000
					: frame_cnt + 16'h0001;
		end
	end

	// Output clocks and frame pulses stay low in internal reset mode.
	generate
		for (g = 0; g < 6; g = g + 1)
		begin : g_clk
			always @(posedge aclk)
			begin
				if (!aresetn || irm)
					pll_clk_out[g] <= 1'b0;
				else if (clk_en)
					pll_clk_out[g] <= nco_acc[31-g];
			end
		end
		for (g = 0; g < 5; g = g + 1)
		begin : g_frm
			always @(posedge aclk)
			begin
				if (!aresetn || irm)
					pll_frame_out[g] <= 1'b0;
				else if (clk_en)
					pll_frame_out[g] <= (frame_cnt <= g);
			end
		end
	endgenerate

endmodule // dtr_pll_ctrl

// *** bench/dtr_ref_src.sv ***
// Reference clock sources at the far side of the timing PLL block.
// Assumes a free-running aclk; every reference changes just after its edge.
`timescale 1ns/1ps

module dtr_ref_src #(
	parameter HALF = 20
) (
	input logic aclk,
	input logic [3:0] alive,
	output logic [3:0] refs
);
	logic [7:0] cnt;

	// ==========================================
	// Live references toggle every HALF cycles; a dead source stops low.
	initial
	begin
		cnt = 8'h00;
		refs = 4'h0;
	end
	always @(posedge aclk)
	begin
		cnt <= (cnt == 8'(HALF - 1)) ? 8'h00 : cnt + 8'h01;
		refs <= ((cnt == 8'(HALF - 1)) ? ~refs : refs) & alive;
	end
endmodule // dtr_ref_src

// *** bench/dtr_pll_ctrl_props.sv ***
// Concurrent checks on the timing PLL control block, from its ports only.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps

module dtr_pll_ctrl_props (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [3:0] ref_ok,
	input wire [5:0] pll_clk_out,
	input wire [4:0] pll_frame_out,
	input wire pll_locked,
	input wire holdover_active,
	input wire [1:0] active_ref
);
	reg [6:0] rc;
	reg irm;
	wire wtake;

	// ==========================================
	// Shadow copies of mode and internal reset, taken at writes whose address and data are accepted in one cycle.
	assign wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rc <= 7'h00;
			irm <= 1'b0;
		end
		else if (wtake && s_axi_wstrb[0])
		begin
			if (s_axi_awaddr == 8'h00)
				rc <= s_axi_wdata[6:0];
			if (s_axi_awaddr == 8'h04)
				irm <= s_axi_wdata[0];
		end
	end

	// ==========================================
	// Bus behaviour and mode checks.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	wr_resp_a: assert property (wtake |=> s_axi_bvalid)
		else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data not held");
	r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	irm_quiet_a: assert property (irm |=> pll_clk_out == 6'h0
		&& pll_frame_out == 5'h0 && !pll_locked) else $error("outputs alive in reset mode");
	hold_mode_a: assert property ((rc[1:0] == 2'h1 && !irm)[*3] |-> holdover_active)
		else $error("forced holdover not shown");
	auto_hold_a: assert property ((rc[1:0] == 2'h2 && ref_ok == 4'h0)[*4]
		|-> holdover_active) else $error("no holdover without references");
	pref_pair_a: assert property (($stable(rc) && rc[1:0] == 2'h2 && rc[6:4] == 3'h1)[*8]
		|-> active_ref == rc[3:2] || active_ref == rc[3:2] + 2'h1)
		else $error("third reference used");
endmodule // dtr_pll_ctrl_props

bind dtr_pll_ctrl dtr_pll_ctrl_props i_dtr_pll_ctrl_props (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .ref_ok, .pll_clk_out, .pll_frame_out, .pll_locked,
	.holdover_active, .active_ref);

// *** bench/dtr_pll_ctrl_tb.sv ***
// Self-checking bench for the timing PLL control block over AXI4-Lite.
// Assumes the design, the reference model and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin \
		n_compared++; \
		if ((g) !== (e)) \
			begin err_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end \
	end

module dtr_pll_ctrl_tb;
	logic aclk, aresetn, clk_en;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, timing_reference_inputs, ref_ok, alive;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, active_ref;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [5:0] pll_clk_out;
	logic [4:0] pll_frame_out;
	logic pll_locked, holdover_active;
	int err_count = 0;
	int n_compared = 0;

	// ==========================================
	// Design, reference sources and clock.
	dtr_pll_ctrl #(.STEP_CYCLES(20)) i_dtr_pll_ctrl (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .timing_reference_inputs, .ref_ok, .pll_clk_out, .pll_frame_out,
		.pll_locked, .holdover_active, .active_ref);
	dtr_ref_src #(.HALF(20)) i_dtr_ref_src (.aclk, .alive, .refs(timing_reference_inputs));
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// ==========================================
	// Bus tasks: each holds its request until taken, raises ready on seeing the answer and takes it at the next edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic bd;
		begin
			bd = 1'b0;
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			while (!bd)
			begin
				@(posedge aclk);
				if (s_axi_awready)
					s_axi_awvalid <= 1'b0;
				if (s_axi_wready)
					s_axi_wvalid <= 1'b0;
				if (s_axi_bvalid && s_axi_bready)
				begin
					bd = 1'b1;
					s_axi_bready <= 1'b0;
					`CHK("bresp", er, s_axi_bresp)
				end
				else if (s_axi_bvalid)
					s_axi_bready <= 1'b1;
			end
		end
	endtask

	task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic [1:0] er);
		logic rdn;
		begin
			rdn = 1'b0;
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			while (!rdn)
			begin
				@(posedge aclk);
				if (s_axi_arready)
					s_axi_arvalid <= 1'b0;
				if (s_axi_rvalid && s_axi_rready)
				begin
					rdn = 1'b1;
					s_axi_rready <= 1'b0;
					d = s_axi_rdata;
					`CHK(nm, e, d & m)
					`CHK("rresp", er, s_axi_rresp)
				end
				else if (s_axi_rvalid)
					s_axi_rready <= 1'b1;
			end
		end
	endtask

	task automatic refs_set(input logic [3:0] v);
		begin
			ref_ok <= v;
			alive <= v;
			repeat (20) @(posedge aclk);
		end
	endtask

	task automatic summarize;
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================
	// Watchdog against a hung handshake.
	initial
	begin
		repeat (20000) @(posedge aclk);
		err_count++;
		summarize();
	end

	// ==========================================
	// Main sequence.
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		s_axi_wstrb = 4'hf;
		clk_en = 1'b1;
		ref_ok = 4'hf;
		alive = 4'hf;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_rd("range", 8'h14, 32'hffffffff, 32'h00000371, 2'h0);
		wr(8'h14, 32'hffffffff, 2'h0);
		chk_rd("range", 8'h14, 32'hffffffff, 32'h00003fff, 2'h0);
		chk_rd("unmapped", 8'h30, 32'hffffffff, 32'h0, 2'h2);
		wr(8'h28, 32'h1, 2'h2);
		wr(8'h20, 32'h28, 2'h0);
		wr(8'h00, 32'h08, 2'h0);
		repeat (300) @(posedge aclk);
		`CHK("active", 2'h2, active_ref)
		`CHK("locked", 1'b1, pll_locked)
		wr(8'h04, 32'h1, 2'h0);
		repeat (4) @(posedge aclk);
		`CHK("clocks", 6'h0, pll_clk_out)
		`CHK("frames", 5'h0, pll_frame_out)
		chk_rd("range", 8'h14, 32'hffffffff, 32'h00003fff, 2'h0);
		chk_rd("ctrl", 8'h04, 32'h1, 32'h1, 2'h0);
		wr(8'h04, 32'h0, 2'h0);
		wr(8'h00, 32'h09, 2'h0);
		repeat (5) @(posedge aclk);
		`CHK("hold", 1'b1, holdover_active)
		refs_set(4'h3);
		wr(8'h00, 32'h02, 2'h0);
		repeat (20) @(posedge aclk);
		`CHK("active", 2'h0, active_ref)
		refs_set(4'h8);
		`CHK("active", 2'h3, active_ref)
		refs_set(4'h0);
		`CHK("hold", 1'b1, holdover_active)
		refs_set(4'h1);
		`CHK("active", 2'h0, active_ref)
		`CHK("hold", 1'b0, holdover_active)
		chk_rd("status", 8'h24, 32'h1f, 32'h1f, 2'h0);
		refs_set(4'hf);
		wr(8'h24, 32'h1f, 2'h0);
		chk_rd("status", 8'h24, 32'h1f, 32'h0, 2'h0);
		refs_set(4'hd);
		wr(8'h00, 32'h16, 2'h0);
		repeat (20) @(posedge aclk);
		`CHK("active", 2'h2, active_ref)
		refs_set(4'h9);
		`CHK("hold", 1'b1, holdover_active)
		wr(8'h00, 32'h1e, 2'h0);
		repeat (4) @(posedge aclk);
		`CHK("active", 2'h3, active_ref)
		refs_set(4'hf);
		// Free running with the bandwidth bypass left off.
		wr(8'h00, 32'h03, 2'h0);
		wr(8'h04, 32'h18, 2'h0);
		wr(8'h08, 32'h123, 2'h0);
		chk_rd("offset", 8'h28, 32'hffff, 32'h123, 2'h0);
		`CHK("locked", 1'b0, pll_locked)
		wr(8'h04, 32'h08, 2'h0);
		wr(8'h08, 32'h200, 2'h0);
		chk_rd("offset", 8'h28, 32'h0, 32'h0, 2'h0);
		`CHK("gradual", 1'b0, d[15:0] === 16'h0200)
		repeat (300) @(posedge aclk);
		chk_rd("offset", 8'h28, 32'hffff, 32'h200, 2'h0);
		wr(8'h04, 32'h18, 2'h0);
		wr(8'h00, 32'h01, 2'h0);
		repeat (5) @(posedge aclk);
		chk_rd("offset", 8'h28, 32'h0, 32'h0, 2'h0);
		r = 2'h0;
		wr(8'h08, 32'h77, 2'h0);
		chk_rd("offset", 8'h28, 32'hffffffff, d, r);
		summarize();
	end
endmodule // dtr_pll_ctrl_tb
